// >>> pif_params.svh
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH
// register offset and bus layout
`define PIF_FLAGS_OFS 8'h0c
`define PIF_AW 8
`define PIF_RESET 8'h00
// bit positions within the flag register
`define PIF_B_PSP 3'd7
`define PIF_B_ADC 3'd6
`define PIF_B_RX 3'd5
`define PIF_B_TX 3'd4
`define PIF_B_SSP 3'd3
`define PIF_B_CCP 3'd2
`define PIF_B_NARROW_TIMER 3'd1
`define PIF_B_WIDE_TIMER 3'd0
// mask of bits that software may write
`define PIF_WR_MASK 8'hcf
`endif

// >>> pif_pkg.sv
package pif_pkg;
   // capture/compare unit operating mode
   typedef enum logic [2:0] {
      PIF_CCP_CAPTURE = 3'b001,
      PIF_CCP_COMPARE = 3'b010,
      PIF_CCP_PWM = 3'b100
   } pif_ccp_mode_t;
   // one-cycle peripheral event pulses
   typedef struct packed {
      logic psp_access;
      logic adc_done;
      logic ssp_done;
      logic ccp_capture;
      logic ccp_match;
      logic narrow_timer_match;
      logic wide_timer_ovf;
   } pif_events_t;
   // bus cycle state
   typedef enum logic [1:0] {
      PIF_BUS_IDLE = 2'b01,
      PIF_BUS_ACK = 2'b10
   } pif_bus_st_t;
endpackage

// >>> pif_flags.sv
`include "pif_params.svh"
`timescale 1ns/10ps
`default_nettype none
module pif_flags (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`PIF_AW-1:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic wb_sel_i,
   output logic [7:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // peripheral side
   input wire pif_pkg::pif_events_t events_i,
   input wire pif_pkg::pif_ccp_mode_t ccp_mode_i,
   input wire logic rx_buf_full_i,
   input wire logic tx_buf_empty_i,
   input wire logic psp_present_i,
   // flag vector for the dispatch logic
   output logic [7:0] peripheral_event_flags_a_o
);
   logic [5:0] flags_r, flags_nxt; // bits 7,6,3,2,1,0
   pif_pkg::pif_bus_st_t bus_r, bus_nxt;
   logic ack_r, ack_nxt, err_r, err_nxt;
   logic [7:0] rdat_r, rdat_nxt;
   logic [7:0] view;
   logic req, hit, wr;
   logic ccp_ev;

   // assemble the register view; buffer bits are live status
   always_comb begin
      view = 8'h00;
      view[`PIF_B_PSP] = flags_r[5];
      view[`PIF_B_ADC] = flags_r[4];
      view[`PIF_B_RX] = rx_buf_full_i;
      view[`PIF_B_TX] = tx_buf_empty_i;
      view[`PIF_B_SSP] = flags_r[3];
      view[`PIF_B_CCP] = flags_r[2];
      view[`PIF_B_NARROW_TIMER] = flags_r[1];
      view[`PIF_B_WIDE_TIMER] = flags_r[0];
   end
   assign peripheral_event_flags_a_o = view;

   // decode a new request, answered once per cycle
   assign req = wb_cyc_i && wb_stb_i && (bus_r == pif_pkg::PIF_BUS_IDLE);
   assign hit = (wb_adr_i == `PIF_FLAGS_OFS);
   assign wr = req && hit && wb_we_i && wb_sel_i;

   // capture/compare event steered by unit mode, pwm ignored
   always_comb begin
      case (ccp_mode_i)
         pif_pkg::PIF_CCP_CAPTURE: ccp_ev = events_i.ccp_capture;
         pif_pkg::PIF_CCP_COMPARE: ccp_ev = events_i.ccp_match;
         pif_pkg::PIF_CCP_PWM: ccp_ev = 1'b0;
         default: ccp_ev = 1'b0;
      endcase
   end

   // flag update: write first, event set wins over a clear
   always_comb begin
      flags_nxt = flags_r;
      if (wr) begin
         flags_nxt[5] = wb_dat_i[`PIF_B_PSP];
         flags_nxt[4] = wb_dat_i[`PIF_B_ADC];
         flags_nxt[3] = wb_dat_i[`PIF_B_SSP];
         flags_nxt[2] = wb_dat_i[`PIF_B_CCP];
         flags_nxt[1] = wb_dat_i[`PIF_B_NARROW_TIMER];
         flags_nxt[0] = wb_dat_i[`PIF_B_WIDE_TIMER];
      end
      // no enable gating here at all
      if (events_i.psp_access) flags_nxt[5] = 1'b1;
      if (events_i.adc_done) flags_nxt[4] = 1'b1;
      if (events_i.ssp_done) flags_nxt[3] = 1'b1;
      if (ccp_ev) flags_nxt[2] = 1'b1;
      if (events_i.narrow_timer_match) flags_nxt[1] = 1'b1;
      if (events_i.wide_timer_ovf) flags_nxt[0] = 1'b1;
      // port absent: bit is held clear whatever happens
      if (!psp_present_i) flags_nxt[5] = 1'b0;
   end

   // bus answer: one ack per request, unmapped address gives err
   always_comb begin
      bus_nxt = pif_pkg::PIF_BUS_IDLE;
      ack_nxt = 1'b0;
      err_nxt = 1'b0;
      rdat_nxt = rdat_r;
      case (bus_r)
         pif_pkg::PIF_BUS_IDLE: begin
            if (req) begin
               bus_nxt = pif_pkg::PIF_BUS_ACK;
               ack_nxt = hit;
               err_nxt = !hit;
               rdat_nxt = hit ? view : 8'h00;
            end
         end
         pif_pkg::PIF_BUS_ACK: bus_nxt = pif_pkg::PIF_BUS_IDLE;
         default: bus_nxt = pif_pkg::PIF_BUS_IDLE;
      endcase
   end

   // flag registers, cleared by reset or by a zero write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= 6'h00;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // bus registers, kept apart so the answer path holds no flag state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_r <= pif_pkg::PIF_BUS_IDLE;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         rdat_r <= `PIF_RESET;
      end else begin
         bus_r <= bus_nxt;
         ack_r <= ack_nxt;
         err_r <= err_nxt;
         rdat_r <= rdat_nxt;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = rdat_r;

   // checks
   adc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.adc_done |=> flags_r[4])
      else $error("conversion flag not set");
   rx_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
      peripheral_event_flags_a_o[5] == rx_buf_full_i)
      else $error("rx bit wrong");
   tx_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
      peripheral_event_flags_a_o[4] == tx_buf_empty_i)
      else $error("tx bit wrong");
   ssp_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_r[3] && !wr |=> flags_r[3])
      else $error("sync serial flag lost");
   cap_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ccp_mode_i == pif_pkg::PIF_CCP_CAPTURE && events_i.ccp_capture
      |=> flags_r[2])
      else $error("capture flag not set");
   cmp_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ccp_mode_i == pif_pkg::PIF_CCP_COMPARE && events_i.ccp_match
      |=> flags_r[2])
      else $error("compare flag not set");
   pwm_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ccp_mode_i == pif_pkg::PIF_CCP_PWM && !flags_r[2]
      && !(wr && wb_dat_i[`PIF_B_CCP]) |=> !flags_r[2])
      else $error("flag set in pwm mode");
   narrow_timer_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.narrow_timer_match |=> flags_r[1])
      else $error("period flag not set");
   ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.wide_timer_ovf && wr |=> flags_r[0])
      else $error("overflow lost to clear");
   psp_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !psp_present_i |=> !flags_r[5])
      else $error("port flag set without port");
   reset_a: assert property (@(posedge clk_i)
      rst_i |=> flags_r == 6'h00)
      else $error("flags not cleared by reset");
   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   // software writes of one set a flag
   adc_wset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_dat_i[`PIF_B_ADC] |=> flags_r[4])
      else $error("conversion flag not written");
   ssp_wset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_dat_i[`PIF_B_SSP] |=> flags_r[3])
      else $error("sync serial flag not written");
   ccp_wset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_dat_i[`PIF_B_CCP] |=> flags_r[2])
      else $error("capture flag not written");
   narrow_timer_wset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_dat_i[`PIF_B_NARROW_TIMER] |=> flags_r[1])
      else $error("period flag not written");
   ovf_wset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_dat_i[`PIF_B_WIDE_TIMER] |=> flags_r[0])
      else $error("overflow flag not written");
   psp_wset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_dat_i[`PIF_B_PSP] && psp_present_i |=> flags_r[5])
      else $error("port flag not written");

   // a zero write with no event in that cycle empties the bit
   adc_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !wb_dat_i[`PIF_B_ADC] && !events_i.adc_done
      |=> !flags_r[4])
      else $error("conversion flag not cleared");
   ssp_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !wb_dat_i[`PIF_B_SSP] && !events_i.ssp_done
      |=> !flags_r[3])
      else $error("sync serial flag not cleared");
   ccp_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !wb_dat_i[`PIF_B_CCP] && !ccp_ev
      |=> !flags_r[2])
      else $error("compare flag not cleared");
   narrow_timer_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !wb_dat_i[`PIF_B_NARROW_TIMER] && !events_i.narrow_timer_match
      |=> !flags_r[1])
      else $error("period flag not cleared");
   ovf_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !wb_dat_i[`PIF_B_WIDE_TIMER] && !events_i.wide_timer_ovf
      |=> !flags_r[0])
      else $error("overflow flag not cleared");
   psp_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && !wb_dat_i[`PIF_B_PSP] && !events_i.psp_access
      |=> !flags_r[5])
      else $error("port flag not cleared");

   // a set flag is only lost to a software write, or bit 7 to an absent port
   adc_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_r[4] && !wr |=> flags_r[4])
      else $error("conversion flag lost");
   cap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_r[2] && !wr |=> flags_r[2])
      else $error("capture flag lost");
   narrow_timer_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_r[1] && !wr |=> flags_r[1])
      else $error("period flag lost");
   ovf_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_r[0] && !wr |=> flags_r[0])
      else $error("overflow flag lost");
   psp_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_r[5] && !wr && psp_present_i |=> flags_r[5])
      else $error("port flag lost");

   // no enable gates a set, the pulse drives the flag, bit 7 only with the port present
   ssp_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.ssp_done |=> flags_r[3])
      else $error("sync serial flag not set");
   psp_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      events_i.psp_access && psp_present_i |=> flags_r[5])
      else $error("port flag not set");

   // an undefined unit mode sets nothing, just as pwm
   odd_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(ccp_mode_i inside {pif_pkg::PIF_CCP_CAPTURE, pif_pkg::PIF_CCP_COMPARE})
      && !flags_r[2] && !(wr && wb_dat_i[`PIF_B_CCP]) |=> !flags_r[2])
      else $error("flag set in undefined mode");

   // answer one cycle after the taking edge, never both kinds
   ack_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && hit |=> wb_ack_o && !wb_err_o)
      else $error("ack not given");
   err_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !hit |=> wb_err_o && !wb_ack_o)
      else $error("err not given");
   rd_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && hit && !wb_we_i |=> wb_dat_o == $past(view))
      else $error("read data wrong");
   bus_legal_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_r == pif_pkg::PIF_BUS_IDLE || bus_r == pif_pkg::PIF_BUS_ACK)
      else $error("bus state illegal");
   reset_bus_a: assert property (@(posedge clk_i)
      rst_i |=> !wb_ack_o && !wb_err_o && wb_dat_o == `PIF_RESET)
      else $error("bus outputs not cleared by reset");

   // reads, refused writes and unmapped cycles leave flags alone
   rd_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && events_i == '0 && psp_present_i
      |=> $stable(flags_r))
      else $error("read changed flags");
   nosel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && wb_we_i && !wb_sel_i && events_i == '0 && psp_present_i
      |=> $stable(flags_r))
      else $error("unselected write changed flags");
   miss_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !hit && events_i == '0 && psp_present_i
      |=> $stable(flags_r))
      else $error("unmapped cycle changed flags");

   // main scenarios
   ovf_c: cover property (@(posedge clk_i) events_i.wide_timer_ovf && wr);
   rd_c: cover property (@(posedge clk_i) req && hit && !wb_we_i);
   clr_c: cover property (@(posedge clk_i) wr && flags_r != 6'h00);
   race_c: cover property (@(posedge clk_i) wr && events_i.adc_done);
   bad_c: cover property (@(posedge clk_i) wb_err_o);
endmodule
`default_nettype wire

// >>> pif_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pif_params.svh"
module pif_flags_tb;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sel = 1;
   logic [7:0] adr = 8'h00, dat = 8'h00, dat_o, flags, q, wd;
   logic ack, err, e, rx = 0, tx = 1, psp = 1;
   pif_pkg::pif_events_t ev = '0;
   pif_pkg::pif_ccp_mode_t mode = pif_pkg::PIF_CCP_CAPTURE;
   int bad_count = 0, checks_done = 0, m = 0, seed = 32'h7063185a;
   // 50 mhz core clock
   always #10 clk_i = ~clk_i;
   pif_flags uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
      .events_i(ev), .ccp_mode_i(mode), .rx_buf_full_i(rx),
      .tx_buf_empty_i(tx), .psp_present_i(psp),
      .peripheral_event_flags_a_o(flags));
   task test_done();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
      checks_done++;
      if (s !== x) begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", nm, x, s);
      end
   endtask
   // model view: bits 5 and 4 are live buffer levels, never stored
   function logic [7:0] expv();
      expv = (8'(m) & `PIF_WR_MASK) | {2'b00, rx, tx, 4'h0};
   endfunction
   // flag bit hit by event i, -1 when the event must be ignored
   function int fb(input int i);
      case (i)
         6: fb = psp ? 7 : -1;
         5: fb = 6;
         4: fb = 3;
         3: fb = (mode == pif_pkg::PIF_CCP_CAPTURE) ? 2 : -1;
         2: fb = (mode == pif_pkg::PIF_CCP_COMPARE) ? 2 : -1;
         default: fb = i;
      endcase
   endfunction
   // classic cycle: hold until ack or err is sampled, then idle a cycle
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(ack | err) && n < 20);
      q = dat_o;
      e = err;
      if (n >= 20) bad_count++;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
   endtask
   task pulse(input int i);
      ev <= pif_pkg::pif_events_t'(7'(1 << i));
      if (fb(i) >= 0) m = m | (1 << fb(i));
      @(posedge clk_i);
      ev <= '0;
      @(posedge clk_i);
   endtask
   // watchdog, far beyond the roughly 170 cycles the run needs
   initial begin
      repeat (3000) @(posedge clk_i);
      bad_count++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      chk("reset", flags, expv());
      bus(0, `PIF_FLAGS_OFS, 8'h00);
      chk("rd_reset", q, expv());
      bus(0, 8'h0d, 8'h00);
      chk("unmapped", {7'h00, e}, 8'h01);
      // every event under capture, compare and pwm; ccp gating by mode
      for (int r = 0; r < 3; r++) begin
         mode <= r == 0 ? pif_pkg::PIF_CCP_CAPTURE : r == 1 ?
            pif_pkg::PIF_CCP_COMPARE : pif_pkg::PIF_CCP_PWM;
         psp <= r != 2;
         @(posedge clk_i);
         for (int i = 0; i < 7; i++) begin
            rx <= 1'($random(seed));
            tx <= 1'($random(seed));
            pulse(i);
            chk("event", flags, expv());
            bus(0, `PIF_FLAGS_OFS, 8'h00);
            chk("rd_event", q, expv());
         end
         bus(1, `PIF_FLAGS_OFS, 8'h00);
         m = 0;
         chk("clear", flags, expv());
      end
      // random writes, byte select random, read-only bits untouched
      psp <= 1;
      repeat (6) begin
         sel <= 1'($random(seed));
         @(posedge clk_i);
         wd = 8'($random(seed));
         bus(1, `PIF_FLAGS_OFS, wd);
         if (sel) m = wd;
         bus(0, `PIF_FLAGS_OFS, 8'h00);
         chk("rd_write", q, expv());
      end
      // set wins when an event meets a clearing write
      sel <= 1;
      m = 0;
      fork
         bus(1, `PIF_FLAGS_OFS, 8'h00);
         pulse(5);
      join
      chk("race", flags, expv());
      test_done();
   end
endmodule
`default_nettype wire
